/* bus_master_pkg.sv */
package bus_master_pkg;

  // ----------------------------------------------------------------
  // Widths and codes
  // ----------------------------------------------------------------
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam logic [2:0] CYCLE_IACK = 3'h7;
  localparam logic [2:0] CYCLE_SUP_DATA = 3'h5;
  localparam logic [19:0] IACK_UPPER_ONES = 20'hFFFFF;
  localparam logic [1:0] RST_STROBES_N = 2'h3;
  localparam logic RST_DIR_READ = 1'b1;

  // A request from the core side of the port.
  typedef struct packed {
    logic [22:0] addr;
    logic [15:0] wdata;
    logic read;
    logic upper;
    logic lower;
    logic iack;
    logic [2:0] level;
    logic [2:0] cycle_type;
  } req_t;

  localparam int REQ_W = $bits(req_t);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_END = 3'b011,
    ST_RELEASED = 3'b100
  } state_t;

endpackage

/* bus_master_port.sv */
`timescale 1ns/1ps
`default_nettype none

module req_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic full, empty;

  assign empty = (wp_r == rp_r);
  assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rp_r[AW-1:0]];

  always_comb begin
    wp_nxt = wp_r + ((in_valid && !full) ? 1'b1 : 1'b0);
    rp_nxt = rp_r + ((out_ready && !empty) ? 1'b1 : 1'b0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  // Storage has no reset; only the pointers define contents.
  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end
endmodule // req_fifo

module bus_master_port #(
  parameter int DEPTH = bus_master_pkg::FIFO_DEPTH
) (
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic REQ_VALID_IN,
  output logic REQ_READY_OUT,
  input wire bus_master_pkg::req_t REQ_IN,
  output logic [15:0] RDATA_OUT,
  output logic DONE_OUT,
  output logic [22:0] WORD_ADDRESS_LINES_OUT,
  output logic WORD_ADDRESS_LINES_OE_OUT,
  input wire logic [15:0] DATA_LINES_IN,
  output logic [15:0] DATA_LINES_OUT,
  output logic DATA_LINES_OE_OUT,
  output logic ADDRESS_VALID_STROBE_N_OUT,
  output logic READ_NOT_WRITE_OUT,
  output logic UPPER_LANE_STROBE_N_OUT,
  output logic LOWER_LANE_STROBE_N_OUT,
  output logic CONTROL_OE_OUT,
  output logic [2:0] CYCLE_TYPE_CODE_OUT,
  input wire logic TRANSFER_ACK_N_IN,
  input wire logic MASTER_REQUEST_N_IN,
  output logic MASTER_GRANT_N_OUT,
  input wire logic GRANT_TAKEN_N_IN
);
  localparam int W = bus_master_pkg::REQ_W;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree.
  logic [2:0] ack_s_r, brq_s_r, bgk_s_r;
  logic [15:0] d1_r, d2_r, d3_r;
  logic ack_q_r, brq_q_r, bgk_q_r;
  logic ack_q_nxt, brq_q_nxt, bgk_q_nxt;

  always_comb begin
    ack_q_nxt = (ack_s_r[1] == ack_s_r[2]) ? ~ack_s_r[2] : ack_q_r;
    brq_q_nxt = (brq_s_r[1] == brq_s_r[2]) ? ~brq_s_r[2] : brq_q_r;
    bgk_q_nxt = (bgk_s_r[1] == bgk_s_r[2]) ? ~bgk_s_r[2] : bgk_q_r;
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ack_s_r <= 3'h7;
      brq_s_r <= 3'h7;
      bgk_s_r <= 3'h7;
      d1_r <= 16'h0000;
      d2_r <= 16'h0000;
      d3_r <= 16'h0000;
      ack_q_r <= 1'b0;
      brq_q_r <= 1'b0;
      bgk_q_r <= 1'b0;
    end else begin
      ack_s_r <= {ack_s_r[1:0], TRANSFER_ACK_N_IN};
      brq_s_r <= {brq_s_r[1:0], MASTER_REQUEST_N_IN};
      bgk_s_r <= {bgk_s_r[1:0], GRANT_TAKEN_N_IN};
      d1_r <= DATA_LINES_IN;
      d2_r <= d1_r;
      d3_r <= d2_r;
      ack_q_r <= ack_q_nxt;
      brq_q_r <= brq_q_nxt;
      bgk_q_r <= bgk_q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Request queue
  // ----------------------------------------------------------------
  logic fifo_valid, fifo_pop;
  logic [W-1:0] fifo_data;
  bus_master_pkg::req_t head;
  assign head = bus_master_pkg::req_t'(fifo_data);

  req_fifo #(.WIDTH(W), .DEPTH(DEPTH)) u_fifo (
    .clk(MCLK_IN),
    .rst_n(RST_N_IN),
    .in_valid(REQ_VALID_IN),
    .in_ready(REQ_READY_OUT),
    .in_data(REQ_IN),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // ----------------------------------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------------------------------
  bus_master_pkg::state_t st_r, st_nxt;
  bus_master_pkg::req_t cur_r, cur_nxt;
  logic grant_r, grant_nxt, done_nxt, done_r;
  logic [15:0] rdata_r, rdata_nxt;

  always_comb begin
    st_nxt = st_r;
    cur_nxt = cur_r;
    grant_nxt = grant_r;
    rdata_nxt = rdata_r;
    done_nxt = 1'b0;
    fifo_pop = 1'b0;
    if (brq_q_r && !grant_r) begin
      grant_nxt = 1'b1;
    end
    case (st_r)
      bus_master_pkg::ST_IDLE: begin
        if (grant_r) begin
          st_nxt = bus_master_pkg::ST_RELEASED;
        end else if (fifo_valid && !brq_q_r) begin
          cur_nxt = head;
          fifo_pop = 1'b1;
          st_nxt = bus_master_pkg::ST_SETUP;
        end
      end
      bus_master_pkg::ST_SETUP: begin
        st_nxt = bus_master_pkg::ST_STROBE;
      end
      bus_master_pkg::ST_STROBE: begin
        if (ack_q_r) begin
          if (cur_r.read) begin
            rdata_nxt = d3_r;
          end
          st_nxt = bus_master_pkg::ST_END;
        end
      end
      bus_master_pkg::ST_END: begin
        if (!ack_q_r) begin
          done_nxt = 1'b1;
          st_nxt = bus_master_pkg::ST_IDLE;
        end
      end
      bus_master_pkg::ST_RELEASED: begin
        // Hold off while other master owns bus.
        if (!brq_q_r && !bgk_q_r) begin
          grant_nxt = 1'b0;
          st_nxt = bus_master_pkg::ST_IDLE;
        end else if (bgk_q_r) begin
          grant_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt = bus_master_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_r <= bus_master_pkg::ST_IDLE;
      cur_r <= '0;
      grant_r <= 1'b0;
      rdata_r <= 16'h0000;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cur_r <= cur_nxt;
      grant_r <= grant_nxt;
      rdata_r <= rdata_nxt;
      done_r <= done_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  logic active, strobing, owned;
  logic [22:0] addr_drv;
  logic [15:0] wdata_drv;

  always_comb begin
    active = (st_r == bus_master_pkg::ST_SETUP) || (st_r == bus_master_pkg::ST_STROBE);
    strobing = (st_r == bus_master_pkg::ST_STROBE);
    owned = (st_r != bus_master_pkg::ST_RELEASED);
    addr_drv = cur_r.addr;
    if (cur_r.iack) begin
      addr_drv = {bus_master_pkg::IACK_UPPER_ONES, cur_r.level};
    end
    wdata_drv = cur_r.wdata;
    if (cur_r.lower && !cur_r.upper) begin
      wdata_drv = {cur_r.wdata[7:0], cur_r.wdata[7:0]};
    end else if (cur_r.upper && !cur_r.lower) begin
      wdata_drv = {cur_r.wdata[15:8], cur_r.wdata[15:8]};
    end
  end

  // Outputs are registered so they change a clean edge after state.
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      WORD_ADDRESS_LINES_OUT <= 23'h000000;
      WORD_ADDRESS_LINES_OE_OUT <= 1'b0;
      DATA_LINES_OUT <= 16'h0000;
      DATA_LINES_OE_OUT <= 1'b0;
      ADDRESS_VALID_STROBE_N_OUT <= 1'b1;
      READ_NOT_WRITE_OUT <= bus_master_pkg::RST_DIR_READ;
      UPPER_LANE_STROBE_N_OUT <= bus_master_pkg::RST_STROBES_N[1];
      LOWER_LANE_STROBE_N_OUT <= bus_master_pkg::RST_STROBES_N[0];
      CONTROL_OE_OUT <= 1'b0;
      CYCLE_TYPE_CODE_OUT <= 3'h0;
    end else begin
      WORD_ADDRESS_LINES_OUT <= addr_drv;
      WORD_ADDRESS_LINES_OE_OUT <= owned;
      DATA_LINES_OUT <= wdata_drv;
      DATA_LINES_OE_OUT <= active && !cur_r.read;
      READ_NOT_WRITE_OUT <= !(active && !cur_r.read);
      ADDRESS_VALID_STROBE_N_OUT <= !active;
      UPPER_LANE_STROBE_N_OUT <= !(strobing && cur_r.upper);
      LOWER_LANE_STROBE_N_OUT <= !(strobing && cur_r.lower);
      CONTROL_OE_OUT <= owned;
      CYCLE_TYPE_CODE_OUT <= cur_r.iack ? bus_master_pkg::CYCLE_IACK : cur_r.cycle_type;
    end
  end

  assign MASTER_GRANT_N_OUT = !grant_r;
  assign RDATA_OUT = rdata_r;
  assign DONE_OUT = done_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_ack_seen;
    st_r == bus_master_pkg::ST_STROBE && ack_q_r;
  endsequence

  a_iack_address: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (!ADDRESS_VALID_STROBE_N_OUT && CYCLE_TYPE_CODE_OUT == bus_master_pkg::CYCLE_IACK)
    |-> WORD_ADDRESS_LINES_OUT[22:3] == bus_master_pkg::IACK_UPPER_ONES)
    else $error("Acknowledge address upper lines not high.");
  a_read_latch: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (s_ack_seen and cur_r.read) |=> rdata_r == $past(d3_r))
    else $error("Read data not latched on acknowledge.");
  a_write_dir: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    DATA_LINES_OE_OUT |-> !READ_NOT_WRITE_OUT)
    else $error("Data driven during read.");
  a_strobe_hold: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (st_r == bus_master_pkg::ST_STROBE && !ack_q_r) |=> !ADDRESS_VALID_STROBE_N_OUT)
    else $error("Strobe dropped before acknowledge.");
  a_byte_copy: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (DATA_LINES_OE_OUT && UPPER_LANE_STROBE_N_OUT && !LOWER_LANE_STROBE_N_OUT)
    |-> DATA_LINES_OUT[15:8] == DATA_LINES_OUT[7:0])
    else $error("Byte not replicated.");
  a_grant_req: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (brq_q_r && !grant_r && st_r != bus_master_pkg::ST_RELEASED) |=> !MASTER_GRANT_N_OUT)
    else $error("Grant not given after request.");
  a_lane_qual: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (!UPPER_LANE_STROBE_N_OUT || !LOWER_LANE_STROBE_N_OUT) |-> !ADDRESS_VALID_STROBE_N_OUT)
    else $error("Lane strobe without address strobe.");
  a_close_cycle: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    s_ack_seen |=> ##[1:8] DONE_OUT)
    else $error("Cycle not closed after acknowledge.");
  a_release_bus: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (st_r == bus_master_pkg::ST_RELEASED) |=> !CONTROL_OE_OUT && !WORD_ADDRESS_LINES_OE_OUT)
    else $error("Bus driven while released.");
endmodule // bus_master_port
`default_nettype wire

/* slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// Slave and rival master
// ----
module slave_model (
  input wire logic clk,
  input wire logic [22:0] addr,
  input wire logic as_n,
  input wire logic [1:0] ds_n,
  input wire logic rnw,
  input wire logic [2:0] code,
  input wire logic [15:0] dq,
  input wire logic stall,
  input wire logic want,
  input wire logic grant_n,
  output logic ack_n,
  output logic [15:0] din,
  output logic req_n,
  output logic taken_n
);
  logic [3:0] n = 4'h0;
  logic [22:0] s_addr;
  logic [15:0] s_data;
  logic [5:0] s_ctl;
  initial begin
    ack_n = 1'b1;
    din = 16'h0000;
    req_n = 1'b1;
    taken_n = 1'b1;
  end
  always @(posedge clk) begin
    if (!as_n && ds_n != 2'h3 && ack_n) begin
      n <= n + 4'h1;
      if (n == 4'h2 && !stall) begin
        ack_n <= 1'b0;
        din <= {addr[7:0] ^ 8'h5A, ~addr[7:0]};
        s_addr <= addr;
        s_data <= dq;
        s_ctl <= {code, rnw, ds_n};
      end
    end else if (ds_n == 2'h3) begin
      n <= 4'h0;
      ack_n <= 1'b1;
      // Released lines toggle so stale data never passes.
      din <= ~din;
    end
  end
  always @(posedge clk) begin
    req_n <= !(want && taken_n);
    // Takes the bus only when idle.
    if (!want)
      taken_n <= 1'b1;
    else if (!grant_n && as_n && ack_n)
      taken_n <= 1'b0;
  end
endmodule // slave_model
`default_nettype wire

/* async_bus_master_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench
// ----
module async_bus_master_port_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic stall = 1'b0;
  logic want = 1'b0;
  bus_master_pkg::req_t req = '0;
  logic ready, done, a_oe, d_oe, as_n, rnw, c_oe, grant_n, ack_n, req_n, taken_n;
  logic [1:0] ds_n;
  logic [2:0] code;
  logic [15:0] rd, dq, din, last_rd;
  logic [22:0] addr;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  // Pull-ups hold the address and data strobes negated while the port floats them.
  wire logic as_w = c_oe ? as_n : 1'b1;
  wire logic [1:0] ds_w = c_oe ? ds_n : 2'h3;
  wire logic [15:0] dq_w = d_oe ? dq : din;
  always #5 clk = ~clk;
  bus_master_port u_bus_master_port (
    .MCLK_IN(clk), .RST_N_IN(rst_n), .REQ_VALID_IN(req_valid),
    .REQ_READY_OUT(ready), .REQ_IN(req), .RDATA_OUT(rd), .DONE_OUT(done),
    .WORD_ADDRESS_LINES_OUT(addr), .WORD_ADDRESS_LINES_OE_OUT(a_oe),
    .DATA_LINES_IN(dq_w), .DATA_LINES_OUT(dq), .DATA_LINES_OE_OUT(d_oe),
    .ADDRESS_VALID_STROBE_N_OUT(as_n), .READ_NOT_WRITE_OUT(rnw),
    .UPPER_LANE_STROBE_N_OUT(ds_n[1]), .LOWER_LANE_STROBE_N_OUT(ds_n[0]),
    .CONTROL_OE_OUT(c_oe), .CYCLE_TYPE_CODE_OUT(code), .TRANSFER_ACK_N_IN(ack_n),
    .MASTER_REQUEST_N_IN(req_n), .MASTER_GRANT_N_OUT(grant_n),
    .GRANT_TAKEN_N_IN(taken_n));
  slave_model u_slave_model (
    .clk(clk), .addr(addr), .as_n(as_w), .ds_n(ds_w), .rnw(rnw), .code(code),
    .dq(dq_w), .stall(stall), .want(want), .grant_n(grant_n), .ack_n(ack_n),
    .din(din), .req_n(req_n), .taken_n(taken_n));
  function automatic bit ck(input bit bad);
    num_checks++;
    return bad;
  endfunction
  task automatic err(input string m);
    fails++;
    $display("ERROR at %0t: %s", $time, m);
  endtask
  // Flags are {read, upper, lower, iack}.
  function automatic bus_master_pkg::req_t mk(input logic [22:0] a,
      input logic [15:0] d, input logic [3:0] f, input logic [2:0] c);
    return '{addr: a, wdata: d, read: f[3], upper: f[2], lower: f[1], iack: f[0],
      level: a[2:0], cycle_type: c};
  endfunction
  task automatic send(input bus_master_pkg::req_t r);
    @(negedge clk);
    req = r;
    req_valid = 1'b1;
    while (ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task automatic finish_all(input int n);
    int t;
    t = 0;
    while (n > 0 && t < 3000) begin
      @(negedge clk);
      t++;
      if (done === 1'b1) begin
        n--;
        last_rd = rd;
      end
    end
    if (ck(n != 0)) err("cycle never ended");
  endtask
  task automatic t_rw();
    logic [15:0] e, m;
    logic [1:0] ln;
    for (int i = 0; i < 6; i++) begin
      ln = (i % 3 == 0) ? 2'h3 : 2'(i % 3);
      send(mk(23'h12340 + 23'(i), 16'hA1B2, {i[0], ln, 1'b0}, 3'h5));
      finish_all(1);
      e = {8'h5A ^ (8'h40 + 8'(i)), ~(8'h40 + 8'(i))};
      m = {{8{ln[1]}}, {8{ln[0]}}};
      if (i[0] == 1'b0)
        e = (ln == 2'h2) ? 16'hA1A1 : (ln == 2'h1) ? 16'hB2B2 : 16'hA1B2;
      if (ck(u_slave_model.s_addr !== 23'h12340 + 23'(i))) err("address");
      if (ck(u_slave_model.s_ctl !== {3'h5, i[0], ~ln})) err("control");
      if (i[0] == 1'b0 && ck(u_slave_model.s_data !== e)) err("write data");
      if (i[0] == 1'b1 && ck((last_rd & m) !== (e & m))) err("read data");
    end
  endtask
  task automatic t_iack();
    logic [22:0] a;
    for (int l = 1; l < 8; l += 6) begin
      a = {20'hFFFFF, 3'(l)};
      send(mk(23'(l), 16'h0000, 4'hB, 3'h7));
      finish_all(1);
      if (ck(u_slave_model.s_addr !== a)) err("iack address");
      if (ck(u_slave_model.s_ctl[5:3] !== 3'h7)) err("iack code");
      if (ck(last_rd[7:0] !== ~a[7:0])) err("vector");
    end
  endtask
  task automatic t_fill();
    int n;
    n = 0;
    @(negedge clk);
    stall = 1'b1;
    req_valid = 1'b1;
    for (int i = 0; i < 20; i++) begin
      req = mk(23'h00100 + 23'(i), 16'h3C00 + 16'(i), 4'h6, 3'h1);
      if (ready !== 1'b1) break;
      n++;
      @(negedge clk);
    end
    req_valid = 1'b0;
    if (ck(n < 16 || n > 17)) err("queue depth");
    if (ck(as_w !== 1'b0 || ds_w !== 2'h0)) err("strobes dropped");
    stall = 1'b0;
    finish_all(n);
    if (ck(u_slave_model.s_data !== 16'h3C00 + 16'(n - 1))) err("last word");
  endtask
  task automatic t_arb();
    int t;
    @(negedge clk);
    want = 1'b1;
    t = 0;
    while (taken_n !== 1'b0 && t < 50) begin
      @(negedge clk);
      t++;
    end
    if (ck(t == 50)) err("no grant");
    repeat (4) @(negedge clk);
    if (ck(c_oe !== 1'b0 || a_oe !== 1'b0)) err("bus not freed");
    send(mk(23'h00200, 16'h5555, 4'h6, 3'h5));
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      if (ck(as_w !== 1'b1 || done === 1'b1)) err("cycle while granted");
    end
    want = 1'b0;
    finish_all(1);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 50000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_rw();
    t_iack();
    t_fill();
    t_arb();
    conclude();
  end
endmodule // async_bus_master_port_test
`default_nettype wire
